// file: hdl/trim_pkg.sv
// Constants and types for the offset trim search controller
// What this block does
// [RULE1] Set calibration mode before reference selection
// [RULE2] Route shared pins to amplifier before calibration
// [RULE3] Amplifier: mode and reference select both one
// [RULE4] Amplifier: write zeros, sample start bit
// [RULE5] Amplifier: increment until bit changes, record low
// [RULE6] Amplifier: write ones, sample new start
// [RULE7] Amplifier: decrement until bit changes, record high
// [RULE8] Amplifier: write mean into six-bit trim
// [RULE9] Odd sum: floor, sum shifted right one
// [RULE10] Comparator: mode and reference select both one
// [RULE11] Comparator: write zeros, sample start bit
// [RULE12] Comparator: increment until change, record low
// [RULE13] Comparator: write ones, sample new start
// [RULE14] Comparator: decrement until change, record high
// [RULE15] Comparator: write floored mean into trim
// [RULE16] Comparator status one when input above reference
// [RULE17] Amplifier status bit valid in calibration mode
// [RULE18] Sweep end without change records end code
// [RULE19] Wait settle cycles after each trim write
package trim_pkg;
  localparam int CODE_W = 6;                       // Widest trim code (amplifier)
  localparam int CMP_W = 5;                        // Comparator trim width
  localparam int SETTLE_W = 16;                    // Settle counter width
  localparam logic [CODE_W-1:0] AMP_MAX = 6'h3F;   // Amplifier all ones
  localparam logic [CODE_W-1:0] CMP_MAX = 6'h1F;   // Comparator all ones
  localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00; // All zeros
  localparam logic [SETTLE_W-1:0] SETTLE_DEF = 16'h0004; // Settle cycles after reset
  // Register map of the controller's own port
  localparam logic [1:0] ADDR_CTRL = 2'h0;   // W: bit0 start, bits2:1 target
  localparam logic [1:0] ADDR_STATUS = 2'h1; // R: bit0 busy, bit1 done
  localparam logic [1:0] ADDR_SETTLE = 2'h2; // R/W: settle cycles
  localparam logic [1:0] ADDR_RESULT = 2'h3; // R: low, high, final codes
  localparam logic [1:0] TGT_AMP0 = 2'h0;    // Target amplifier 0
  localparam logic [1:0] TGT_AMP1 = 2'h1;    // Target amplifier 1
  localparam logic [1:0] TGT_CMP = 2'h2;     // Target comparator
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_MODE = 4'h1, S_REF = 4'h2, S_LOAD0 = 4'h3, S_START0 = 4'h4,
    S_UP = 4'h5, S_LOAD1 = 4'h6, S_START1 = 4'h7, S_DOWN = 4'h8, S_FINAL = 4'h9,
    S_PINS = 4'hA
  } state_t;
endpackage : trim_pkg

// file: hdl/settle_timer.sv
// Settle delay counter started on each trim write
`timescale 1ns/1ps
`default_nettype none
module settle_timer
  import trim_pkg::*;
(
  input wire logic clk,                  // System clock
  input wire logic rst,                  // Async reset, high
  input wire logic start,                // Restart after a trim write
  input wire logic [SETTLE_W-1:0] cycles, // Cycles to wait
  output logic ready                     // Output bit may be sampled
);
  logic [SETTLE_W-1:0] cnt_q; // Remaining cycles
  // Count down; zero means settled. A zero setting still waits one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= (cycles == '0) ? SETTLE_W'(1) : cycles; // RULE19
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - SETTLE_W'(1);
    end
  end
  // Ready must not look at start: the sequencer derives start from ready
  assign ready = (cnt_q == '0);
endmodule : settle_timer
`default_nettype wire

// file: hdl/trim_search.sv
// Offset trim search controller for amplifiers and comparator
`timescale 1ns/1ps
`default_nettype none
module trim_search
  import trim_pkg::*;
(
  input wire logic SYS_CLK,                     // 100 MHz clock
  input wire logic RST,                         // Async reset, high
  input wire logic [1:0] ADDR,                  // Register address
  input wire logic [15:0] WDATA,                // Write data
  input wire logic WR,                          // Write strobe
  input wire logic RD,                          // Read strobe
  output logic [17:0] RDATA,                    // Read data, cycle after RD
  output logic PIN_AMP_SEL,                     // Shared pins to amplifier inputs
  output logic [1:0] AMP_TRIM_MODE_SEL,         // Amplifier calibration mode
  output logic [1:0] AMP_TRIM_REF_SEL,          // Amplifier reference select
  output logic [CODE_W-1:0] AMP0_TRIM_CODE,     // Amplifier 0 trim
  output logic [CODE_W-1:0] AMP1_TRIM_CODE,     // Amplifier 1 trim
  input wire logic [1:0] AMP_TRIM_OUT_STATUS,   // Amplifier outputs in calibration
  output logic CMP_TRIM_MODE_SEL,               // Comparator calibration mode
  output logic CMP_TRIM_REF_SEL,                // Comparator reference select
  output logic [CMP_W-1:0] CMP_TRIM_CODE,       // Comparator trim
  input wire logic CMP_OUT_STATUS               // Comparator output
);
  state_t state_q;                    // Sequencer state
  logic [1:0] tgt_q;                  // Target being trimmed
  logic [SETTLE_W-1:0] settle_q;      // Settle setting
  logic [CODE_W-1:0] code_q;          // Code being driven to target
  logic [CODE_W-1:0] low_q;           // Low-side crossing
  logic [CODE_W-1:0] high_q;          // High-side crossing
  logic [CODE_W-1:0] final_q;         // Resulting trim
  logic ref_bit_q;                    // Starting output value
  logic done_q;                       // Last run complete
  localparam int N_TGT = 3;           // Two amplifiers and one comparator
  logic [2:0] mode_q;                 // Calibration mode per target
  logic [2:0] refsel_q;               // Reference select per target
  logic [2:0] tgt_sel;                // One-hot form of the target
  logic pin_sel_q;                    // Shared pins routed to amplifiers
  logic [CODE_W-1:0] code_d;          // Next code to drive
  logic up_hit;                       // Upward sweep ends this cycle
  logic down_hit;                     // Downward sweep ends this cycle
  logic busy;                         // Sequencer not idle
  logic [1:0] amp_s1_q, amp_s2_q;     // Amplifier status sync
  logic cmp_s1_q, cmp_s2_q;           // Comparator status sync
  logic obs;                          // Synchronised output of target
  logic ready;                        // Settle done
  logic wr_code;                      // Code written this cycle
  logic [CODE_W-1:0] code_max;        // All ones for target
  logic [CODE_W:0] sum;               // Crossing sum, one bit wider
  logic start_req;                    // Start command

  // All checks below run on the system clock and sleep during reset
  default clocking main_cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // Status inputs come from analog, so they pass two flip-flops
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      amp_s1_q <= 2'h0;
      amp_s2_q <= 2'h0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      amp_s1_q <= AMP_TRIM_OUT_STATUS;
      amp_s2_q <= amp_s1_q;
      cmp_s1_q <= CMP_OUT_STATUS;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Observed bit of the chosen target
  always_comb begin
    if (tgt_q == TGT_CMP) begin
      obs = cmp_s2_q;       // RULE16
    end else begin
      obs = amp_s2_q[tgt_q[0]]; // RULE17
    end
  end

  // Decodes a target number to one bit per trim target
  function automatic logic [2:0] tgt_onehot(input logic [1:0] t);
    logic [2:0] oh; // One bit per target
    oh = 3'h0;
    if (t == TGT_CMP) begin
      oh[2] = 1'b1;
    end else if (t == TGT_AMP1) begin
      oh[1] = 1'b1;
    end else begin
      oh[0] = 1'b1;
    end
    return oh;
  endfunction : tgt_onehot

  assign tgt_sel = tgt_onehot(tgt_q);
  assign code_max = (tgt_q == TGT_CMP) ? CMP_MAX : AMP_MAX;
  assign sum = {1'b0, low_q} + {1'b0, high_q};
  assign start_req = WR && (ADDR == ADDR_CTRL) && WDATA[0] && (state_q == S_IDLE);
  assign busy = (state_q != S_IDLE);
  // A sweep ends on the first change of the bit, or at the end of the range
  assign up_hit = (state_q == S_UP) && ready && (obs != ref_bit_q || code_q == code_max);
  assign down_hit = (state_q == S_DOWN) && ready && (obs != ref_bit_q || code_q == CODE_ZERO);

  // Next trim code and its load strobe; each load restarts the settle wait
  always_comb begin
    wr_code = 1'b0;
    code_d = code_q;
    case (state_q)
      S_REF: begin
        wr_code = 1'b1;
        code_d = CODE_ZERO;             // RULE4 RULE11
      end
      S_START0: begin
        if (ready) begin
          wr_code = 1'b1;
          code_d = code_q + CODE_W'(1); // RULE5 RULE12
        end
      end
      S_UP: begin
        if (up_hit) begin
          wr_code = 1'b1;
          code_d = code_max;            // RULE6 RULE13
        end else if (ready) begin
          wr_code = 1'b1;
          code_d = code_q + CODE_W'(1); // RULE5 RULE12
        end
      end
      S_START1: begin
        if (ready) begin
          wr_code = 1'b1;
          code_d = code_q - CODE_W'(1); // RULE7 RULE14
        end
      end
      S_DOWN: begin
        if (ready && !down_hit) begin
          wr_code = 1'b1;
          code_d = code_q - CODE_W'(1); // RULE7 RULE14
        end
      end
      S_FINAL: begin
        wr_code = 1'b1;
        code_d = sum[CODE_W:1];         // RULE8 RULE9 RULE15
      end
      default: wr_code = 1'b0;
    endcase
  end

  // The wait keeps a sweep from reading the bit before the analog side settles
  settle_timer u_settle (
    .clk(SYS_CLK),
    .rst(RST),
    .start(wr_code),
    .cycles(settle_q),
    .ready(ready)
  );

  // Settle setting written by software
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      settle_q <= SETTLE_DEF;
    end else if (WR && ADDR == ADDR_SETTLE) begin
      settle_q <= WDATA[SETTLE_W-1:0];
    end
  end

  // Sequencer: pins (amplifier targets only), mode, reference, upward sweep, downward sweep, final write
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      tgt_q <= TGT_AMP0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start_req) begin
            tgt_q <= (WDATA[2:1] == TGT_CMP) ? TGT_CMP : {1'b0, WDATA[1]};
            state_q <= (WDATA[2:1] == TGT_CMP) ? S_MODE : S_PINS;
          end
        end
        S_PINS: state_q <= S_MODE;                              // RULE2
        S_MODE: state_q <= S_REF;                               // RULE1
        S_REF: state_q <= S_START0;
        S_START0: state_q <= ready ? S_UP : S_START0;           // RULE4 RULE11
        S_UP: state_q <= up_hit ? S_START1 : S_UP;              // RULE5 RULE12
        S_START1: state_q <= ready ? S_DOWN : S_START1;         // RULE6 RULE13
        S_DOWN: state_q <= down_hit ? S_FINAL : S_DOWN;         // RULE7 RULE14
        S_FINAL: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Code being swept; it moves only on a load strobe
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      code_q <= CODE_ZERO;
    end else if (wr_code) begin
      code_q <= code_d;
    end
  end

  // Starting value is taken once the zero or all-ones load has settled
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ref_bit_q <= 1'b0;
    end else if ((state_q == S_START0 || state_q == S_START1) && ready) begin
      ref_bit_q <= obs;                 // RULE4 RULE6 RULE11 RULE13
    end
  end

  // Crossing codes, result and done flag; they stay readable after the run
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      low_q <= CODE_ZERO;
      high_q <= CODE_ZERO;
      final_q <= CODE_ZERO;
      done_q <= 1'b0;
    end else begin
      if (up_hit) begin
        low_q <= code_q;                // RULE5 RULE12 RULE18
      end
      if (down_hit) begin
        high_q <= code_q;               // RULE7 RULE14 RULE18
      end
      if (state_q == S_FINAL) begin
        final_q <= sum[CODE_W:1];       // RULE8 RULE9 RULE15
        done_q <= 1'b1;
      end else if (start_req) begin
        done_q <= 1'b0;
      end
    end
  end

  // Pins go first, mode a cycle before the reference; mode and reference drop at the end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_sel_q <= 1'b0;
      mode_q <= 3'h0;
      refsel_q <= 3'h0;
    end else if (state_q == S_PINS) begin
      pin_sel_q <= 1'b1;                // RULE2
    end else if (state_q == S_MODE) begin
      mode_q <= mode_q | tgt_sel;       // RULE1 RULE3 RULE10
    end else if (state_q == S_REF) begin
      refsel_q <= refsel_q | tgt_sel;   // RULE1 RULE3 RULE10
    end else if (state_q == S_FINAL) begin
      mode_q <= 3'h0;
      refsel_q <= 3'h0;
    end
  end

  // One trim register per target keeps its code once the run is over
  for (genvar g = 0; g < N_TGT; g++) begin : g_trim
    logic [CODE_W-1:0] val_q; // Code driven to this target
    always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
        val_q <= CODE_ZERO;
      end else if (wr_code && tgt_sel[g]) begin
        val_q <= code_d;              // RULE4 RULE8 RULE15
      end
    end
  end

  // Analog controls come straight from flip-flops
  assign PIN_AMP_SEL = pin_sel_q;
  assign AMP_TRIM_MODE_SEL = mode_q[1:0];
  assign AMP_TRIM_REF_SEL = refsel_q[1:0];
  assign CMP_TRIM_MODE_SEL = mode_q[2];
  assign CMP_TRIM_REF_SEL = refsel_q[2];
  assign AMP0_TRIM_CODE = g_trim[0].val_q;
  assign AMP1_TRIM_CODE = g_trim[1].val_q;
  assign CMP_TRIM_CODE = g_trim[2].val_q[CMP_W-1:0];

  // Read data stand in the cycle after the strobe and are cleared otherwise
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 18'h00000;
    end else if (RD) begin
      if (ADDR == ADDR_STATUS) begin
        RDATA <= {16'h0000, done_q, busy};
      end else if (ADDR == ADDR_SETTLE) begin
        RDATA <= {2'h0, settle_q};
      end else if (ADDR == ADDR_RESULT) begin
        RDATA <= {low_q, high_q, final_q};
      end else begin
        RDATA <= {15'h0000, tgt_q, busy};
      end
    end else begin
      RDATA <= 18'h00000;
    end
  end

  // Sequence checks on what reaches the analog side
  ref_after_mode_a: assert property ((refsel_q != 3'h0) |-> (mode_q == refsel_q)) // RULE1
    else $error("reference select set without calibration mode");
  pins_first_a: assert property ((mode_q[1:0] != 2'h0) |-> pin_sel_q) // RULE2
    else $error("amplifier calibrated before pin routing");
  up_start_a: assert property ((state_q == S_START0) |-> (code_q == CODE_ZERO)) // RULE4 RULE11
    else $error("upward sweep does not start at zero");
  up_step_a: assert property ((state_q == S_UP && ready && !up_hit) |=> // RULE5 RULE12
    (code_q == $past(code_q) + CODE_W'(1)))
    else $error("upward sweep step is not one");
  down_start_a: assert property ((state_q == S_START1) |-> (code_q == code_max)) // RULE6 RULE13
    else $error("downward sweep does not start at all ones");
  down_step_a: assert property ((state_q == S_DOWN && ready && !down_hit) |=> // RULE7 RULE14
    (code_q == $past(code_q) - CODE_W'(1)))
    else $error("downward sweep step is not one");
  final_mean_a: assert property ((state_q == S_FINAL) |=> // RULE8 RULE9 RULE15
    (final_q == CODE_W'(({1'b0, low_q} + {1'b0, high_q}) >> 1)))
    else $error("final code is not the floored mean");
  range_end_a: assert property ((state_q == S_UP && ready && code_q == code_max) |=> // RULE18
    (state_q == S_START1 && low_q == code_max))
    else $error("sweep ran past the end of the range");
  settle_hold_a: assert property ((state_q == S_UP && !ready) |=> (code_q == $past(code_q))) // RULE19
    else $error("code moved before the settle wait ended");
  amp_run_c: cover property (state_q == S_FINAL && tgt_q != TGT_CMP);
  cmp_run_c: cover property (state_q == S_FINAL && tgt_q == TGT_CMP);
  range_end_c: cover property (state_q == S_UP && ready && code_q == code_max && obs == ref_bit_q);
endmodule : trim_search
`default_nettype wire

// file: verif/trim_analog_model.sv
// Behavioural trim-able amplifier or comparator with offset and hysteresis
`timescale 1ns/1ps
`default_nettype none
module trim_analog_model (
  input wire logic clk,        // System clock
  input wire logic mode,       // Calibration mode select
  input wire logic [6:0] code, // Trim code, zero extended
  input wire logic [6:0] thr,  // Code where the output falls
  input wire logic [6:0] hys,  // Extra codes needed to rise
  input wire logic [1:0] lag,  // Output delay in cycles
  output logic out_status      // Output bit seen by the controller
);
  logic level_q = 1'b0;      // Comparison result with hysteresis
  logic [2:0] pipe_q = 3'h0; // Delayed copies for a slow output
  logic flip_q = 1'b0;       // Meaningless toggle outside calibration
  // Hysteresis makes the two crossing codes differ, so the mean matters
  always @(posedge clk) begin
    if (code >= thr + hys) level_q <= 1'b1;
    else if (code < thr) level_q <= 1'b0;
    pipe_q <= {pipe_q[1:0], level_q};
    flip_q <= ~flip_q;
  end
  // Status only means something in calibration mode
  assign out_status = mode ? ((lag == 2'h0) ? level_q : pipe_q[lag - 2'h1]) : flip_q;
endmodule : trim_analog_model
`default_nettype wire

// file: verif/trim_search_test.sv
// Self-checking bench for the offset trim search controller
`timescale 1ns/1ps
`default_nettype none
module trim_search_test;
  import trim_pkg::*;
  logic SYS_CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [1:0] ADDR = 2'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [17:0] RDATA;
  logic PIN_AMP_SEL, CMP_TRIM_MODE_SEL, CMP_TRIM_REF_SEL;
  logic [1:0] AMP_TRIM_MODE_SEL, AMP_TRIM_REF_SEL;
  logic [CODE_W-1:0] AMP0_TRIM_CODE, AMP1_TRIM_CODE;
  logic [CMP_W-1:0] CMP_TRIM_CODE;
  logic [6:0] thr [3] = '{7'h01, 7'h01, 7'h01}; // Model offsets
  logic [6:0] hys [3] = '{7'h00, 7'h00, 7'h00}; // Model hysteresis
  logic [1:0] lag = 2'h0;                       // Model response delay
  logic [2:0] mode_p = 3'h0, refs_p = 3'h0, both = 3'h0;
  logic [7:0] exp_q [$];                        // Target and expected final code
  logic [19:0] rnd = 20'h14070;                 // Starts at 82032
  int n_fail = 0, comparisons = 0;
  event result_ev;
  wire [2:0] outs;
  wire [2:0] mode = {CMP_TRIM_MODE_SEL, AMP_TRIM_MODE_SEL};
  wire [2:0] refs = {CMP_TRIM_REF_SEL, AMP_TRIM_REF_SEL};
  wire [6:0] code_w [3];
  assign code_w[0] = {1'b0, AMP0_TRIM_CODE};
  assign code_w[1] = {1'b0, AMP1_TRIM_CODE};
  assign code_w[2] = {2'h0, CMP_TRIM_CODE};
  trim_search dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PIN_AMP_SEL(PIN_AMP_SEL), .AMP_TRIM_MODE_SEL(AMP_TRIM_MODE_SEL),
    .AMP_TRIM_REF_SEL(AMP_TRIM_REF_SEL), .AMP0_TRIM_CODE(AMP0_TRIM_CODE),
    .AMP1_TRIM_CODE(AMP1_TRIM_CODE), .AMP_TRIM_OUT_STATUS(outs[1:0]),
    .CMP_TRIM_MODE_SEL(CMP_TRIM_MODE_SEL), .CMP_TRIM_REF_SEL(CMP_TRIM_REF_SEL),
    .CMP_TRIM_CODE(CMP_TRIM_CODE), .CMP_OUT_STATUS(outs[2]));
  // One analog unit per trim target
  for (genvar g = 0; g < 3; g++) begin : g_unit
    trim_analog_model u_unit (.clk(SYS_CLK), .mode(mode[g]), .code(code_w[g]), .thr(thr[g]),
      .hys(hys[g]), .lag(lag), .out_status(outs[g]));
  end
  initial forever #5 SYS_CLK = ~SYS_CLK;
  function automatic logic [19:0] lfsr(input logic [19:0] v);
    return {v[18:0], v[19] ^ v[16]};
  endfunction : lfsr
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [17:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    @(negedge SYS_CLK);
    d = RDATA;
  endtask : rd
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Order of mode, reference and pin routing as seen on the wires
  always @(posedge SYS_CLK) begin
    if (|(refs & ~refs_p)) check("mode first", {15'h0, refs & ~refs_p}, {15'h0, refs & ~refs_p & mode_p});
    if (|(mode[1:0] & ~mode_p[1:0])) check("pin route", 18'h1, {17'h0, PIN_AMP_SEL});
    both <= both | (mode & refs);
    mode_p <= mode;
    refs_p <= refs;
  end
  // Oldest expectation is matched against the trim port once a run ends
  always @(result_ev) begin
    check("final code", {11'h0, exp_q[0][6:0] & 7'h3F}, {11'h0, code_w[exp_q[0][7:6]]});
    check("mode and ref", 18'h1, {17'h0, both[exp_q[0][7:6]]});
    void'(exp_q.pop_front());
    both = 3'h0;
  end
  task automatic calib(input logic [1:0] tgt, input logic [6:0] t, input logic [6:0] h);
    logic [6:0] mx, lo, hi, fin;
    logic [17:0] s;
    mx = (tgt == TGT_CMP) ? 7'h1F : 7'h3F;
    thr[tgt] = t;
    hys[tgt] = h;
    lo = (t + h > mx) ? mx : t + h;
    hi = (t + h > mx) ? 7'h00 : t - 7'h01;
    fin = (lo + hi) >> 1;
    exp_q.push_back({tgt, fin[5:0]});
    wr(ADDR_CTRL, {13'h0, tgt, 1'b1});
    rd(ADDR_STATUS, s);
    check("busy", 18'h1, {17'h0, s[0]});
    for (int n = 0; n < 4000 && s[1] !== 1'b1; n++) rd(ADDR_STATUS, s);
    check("done", 18'h1, {17'h0, s[1]});
    rd(ADDR_RESULT, s);
    check("crossings", {lo[5:0], hi[5:0], fin[5:0]}, s);
    -> result_ev;
    $display("test target %0d offset %0d hysteresis %0d ended", tgt, t, h);
  endtask : calib
  initial begin
    logic [17:0] s;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(ADDR_SETTLE, s);
    check("settle reset", {2'h0, SETTLE_DEF}, s);
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      lag = rnd[1:0];
      // Settle outlasts the slowest model response
      wr(ADDR_SETTLE, 16'h0006 + {14'h0, rnd[3:2]});
      rd(ADDR_SETTLE, s);
      check("settle", {14'h0, 4'h6 + {2'h0, rnd[3:2]}}, s);
      if (i == 6) calib(TGT_AMP0, 7'h3F, 7'h01);
      else calib(2'(i % 3), {2'h0, rnd[8:4]} + 7'h01, {4'h0, rnd[11:9]});
    end
    repeat (4) @(posedge SYS_CLK);
    give_verdict();
  end
  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end
endmodule : trim_search_test
`default_nettype wire
